// file: pkg/tc16_pkg.sv
// Constants and carrier types for the 16-bit timer compare output block
package tc16_pkg;

  localparam int          CNT_W       = 16;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic        OC_RESET    = 1'h0;
  localparam logic        PIN_RESET   = 1'h0;
  localparam logic        OE_N_RESET  = 1'h1;

  // Waveform generation mode codes
  localparam logic [3:0]  WGM_NORMAL    = 4'h0;
  localparam logic [3:0]  WGM_CTC_CMPA  = 4'h4;
  localparam logic [3:0]  WGM_CTC_CAP   = 4'hC;
  localparam logic [3:0]  WGM_FPWM_CAP  = 4'hE;
  localparam logic [3:0]  WGM_FPWM_CMPA = 4'hF;

  // Compare output mode codes
  localparam logic [1:0]  COM_NONE   = 2'h0;
  localparam logic [1:0]  COM_TOGGLE = 2'h1;
  localparam logic [1:0]  COM_CLEAR  = 2'h2;
  localparam logic [1:0]  COM_SET    = 2'h3;

  typedef struct packed {
    logic ovf;
    logic cmpa;
    logic cmpb;
    logic cap;
  } tc16_flags_s;

  localparam tc16_flags_s FLAGS_RESET = '{ovf: 1'h0, cmpa: 1'h0, cmpb: 1'h0, cap: 1'h0};

endpackage

// file: design/tc16_core.sv
// 16-bit timer core: Normal and clear-on-match counting, compare outputs and pin override
// Operation
// - Counter write blocks matches at next tick
// - Blocked variable top lets counter reach maximum
// - Output state survives waveform mode changes
// - Output mode change acts from next match
// - Reset clears output state to zero
// - Nonzero output mode routes state to pin
// - Direction bit alone enables the pin driver
// - Output mode never touches capture handling
// - Output mode zero leaves state unchanged
// - Force strobe applies action immediately, non-PWM
// - Waveform mode sets counting, output mode action
// - Normal mode increments and wraps at maximum
// - Normal wrap sets overflow; counting never clears
// - Counter write accepted at any time
// - Clear-on-match clears counter after top equality
// - Top reach flagged by compare A or capture
// - Top below count is missed until wrap
// - Toggle mode flips output A each match
// - Toggle period is two times (1+top) ticks
// - Clear-on-match wrap at maximum sets overflow
// - Equality sets compare flag at that tick
// - Force updates state only, no flag, no clear
`timescale 1ns/1ps
module tc16_core (
  input  wire logic                 CLK_IN,
  input  wire logic                 NRST_IN,
  input  wire logic                 TICK_IN,
  input  wire logic [3:0]           WAVEFORM_GEN_MODE_IN,
  input  wire logic [1:0]           COMPARE_A_OUTPUT_MODE_IN,
  input  wire logic [1:0]           COMPARE_B_OUTPUT_MODE_IN,
  input  wire logic                 FORCE_COMPARE_STROBE_A_IN,
  input  wire logic                 FORCE_COMPARE_STROBE_B_IN,
  input  wire logic                 COUNTER_WR_IN,
  input  wire logic [15:0]          COUNTER_WDATA_IN,
  input  wire logic [15:0]          COMPARE_A_VALUE_IN,
  input  wire logic [15:0]          COMPARE_B_VALUE_IN,
  input  wire logic [15:0]          CAPTURE_VALUE_IN,
  input  wire tc16_pkg::tc16_flags_s FLAG_CLR_IN,
  input  wire logic                 PORT_A_IN,
  input  wire logic                 PORT_B_IN,
  input  wire logic                 OUTPUT_A_PIN_DIRECTION_IN,
  input  wire logic                 OUTPUT_B_PIN_DIRECTION_IN,
  output logic [15:0]               COUNTER_VALUE_OUT,
  output tc16_pkg::tc16_flags_s     FLAG_OUT,
  output logic                      COMPARE_A_OUTPUT_STATE_OUT,
  output logic                      COMPARE_B_OUTPUT_STATE_OUT,
  output logic                      PIN_A_OUT,
  output logic                      PIN_A_OE_N_OUT,
  output logic                      PIN_B_OUT,
  output logic                      PIN_B_OE_N_OUT
);

  logic [15:0]           count;
  logic [15:0]           next_count;
  logic                  blocked;
  logic                  next_blocked;
  tc16_pkg::tc16_flags_s flags;
  tc16_pkg::tc16_flags_s next_flags;
  logic                  oc_a;
  logic                  oc_b;
  logic                  next_oc_a;
  logic                  next_oc_b;
  logic                  pin_a;
  logic                  pin_b;
  logic                  oe_n_a;
  logic                  oe_n_b;
  logic                  next_pin_a;
  logic                  next_pin_b;
  logic                  next_oe_n_a;
  logic                  next_oe_n_b;

  logic                  non_pwm;
  logic                  fast_pwm;
  logic                  top_is_cap;
  logic                  has_top;
  logic [15:0]           top_val;
  logic                  match_a;
  logic                  match_b;
  logic                  match_top;
  logic                  wrap;

  // Set, clear or toggle in non-PWM modes; zero keeps the state
  function automatic logic oc_action(input logic [1:0] com, input logic oc);
    logic r;
    r = oc;
    unique case (com)
      tc16_pkg::COM_NONE:   r = oc;
      tc16_pkg::COM_TOGGLE: r = ~oc;
      tc16_pkg::COM_CLEAR:  r = 1'h0;
      tc16_pkg::COM_SET:    r = 1'h1;
    endcase
    return r;
  endfunction

  // Fast PWM: clear or set on match, opposite at bottom; toggle only for channel A
  function automatic logic pwm_action(input logic [1:0] com, input logic oc, input logic at_match,
                                      input logic is_a);
    logic r;
    r = oc;
    unique case (com)
      tc16_pkg::COM_NONE:   r = oc;
      tc16_pkg::COM_TOGGLE: r = (is_a && at_match) ? ~oc : oc;
      tc16_pkg::COM_CLEAR:  r = ~at_match;
      tc16_pkg::COM_SET:    r = at_match;
    endcase
    return r;
  endfunction

  // Mode decode; the output mode bits play no part here
  always_comb
  begin
    non_pwm    = (WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_NORMAL) ||
                 (WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_CTC_CMPA) ||
                 (WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_CTC_CAP);
    fast_pwm   = (WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_FPWM_CAP) ||
                 (WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_FPWM_CMPA);
    top_is_cap = (WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_CTC_CAP) ||
                 (WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_FPWM_CAP);
    has_top    = fast_pwm || (WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_CTC_CMPA) ||
                 (WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_CTC_CAP);
    // Capture value is only read as top; capture hardware lives elsewhere
    top_val    = top_is_cap ? CAPTURE_VALUE_IN : COMPARE_A_VALUE_IN;
    // A tick right after a counter write sees no matches at all
    match_a    = TICK_IN && !blocked && (count == COMPARE_A_VALUE_IN);
    match_b    = TICK_IN && !blocked && (count == COMPARE_B_VALUE_IN);
    // Top is compared directly: a top written below count is missed until wrap
    match_top  = TICK_IN && !blocked && has_top && (count == top_val);
    wrap       = TICK_IN && !match_top && (count == tc16_pkg::CNT_MAX);
  end

  // Counter, blocking and flags
  always_comb
  begin
    next_count   = count;
    next_blocked = blocked;
    next_flags   = flags;
    if (TICK_IN)
    begin
      next_blocked = 1'h0;
      if (match_top)
        next_count = tc16_pkg::CNT_BOTTOM;
      else
        next_count = 16'(count + 16'h0001);
    end
    if (COUNTER_WR_IN)
    begin
      next_count   = COUNTER_WDATA_IN;
      next_blocked = 1'h1;
    end
    // Software clears first so a same-cycle hardware set wins
    next_flags.ovf  = (flags.ovf  & ~FLAG_CLR_IN.ovf)  | (!COUNTER_WR_IN &&
                      (wrap || (fast_pwm && match_top)));
    next_flags.cmpa = (flags.cmpa & ~FLAG_CLR_IN.cmpa) | match_a;
    next_flags.cmpb = (flags.cmpb & ~FLAG_CLR_IN.cmpb) | match_b;
    next_flags.cap  = (flags.cap  & ~FLAG_CLR_IN.cap)  | (match_top && top_is_cap);
  end

  // Output state and pin override
  always_comb
  begin
    next_oc_a = oc_a;
    next_oc_b = oc_b;
    if (non_pwm)
    begin
      // Force acts like a match on the state only
      if (match_a || FORCE_COMPARE_STROBE_A_IN)
        next_oc_a = oc_action(COMPARE_A_OUTPUT_MODE_IN, oc_a);
      if (match_b || FORCE_COMPARE_STROBE_B_IN)
        next_oc_b = oc_action(COMPARE_B_OUTPUT_MODE_IN, oc_b);
    end
    else if (fast_pwm)
    begin
      if (match_a)
        next_oc_a = pwm_action(COMPARE_A_OUTPUT_MODE_IN, oc_a, 1'h1, 1'h1);
      else if (match_top)
        next_oc_a = pwm_action(COMPARE_A_OUTPUT_MODE_IN, oc_a, 1'h0, 1'h1);
      if (match_b)
        next_oc_b = pwm_action(COMPARE_B_OUTPUT_MODE_IN, oc_b, 1'h1, 1'h0);
      else if (match_top)
        next_oc_b = pwm_action(COMPARE_B_OUTPUT_MODE_IN, oc_b, 1'h0, 1'h0);
    end
    // Other modes hold the state; it is never reloaded on a mode change
    next_pin_a  = (COMPARE_A_OUTPUT_MODE_IN != tc16_pkg::COM_NONE) ? next_oc_a : PORT_A_IN;
    next_pin_b  = (COMPARE_B_OUTPUT_MODE_IN != tc16_pkg::COM_NONE) ? next_oc_b : PORT_B_IN;
    next_oe_n_a = ~OUTPUT_A_PIN_DIRECTION_IN;
    next_oe_n_b = ~OUTPUT_B_PIN_DIRECTION_IN;
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      count   <= tc16_pkg::CNT_RESET;
      blocked <= 1'h0;
      flags   <= tc16_pkg::FLAGS_RESET;
      oc_a    <= tc16_pkg::OC_RESET;
      oc_b    <= tc16_pkg::OC_RESET;
      pin_a   <= tc16_pkg::PIN_RESET;
      pin_b   <= tc16_pkg::PIN_RESET;
      oe_n_a  <= tc16_pkg::OE_N_RESET;
      oe_n_b  <= tc16_pkg::OE_N_RESET;
    end
    else
    begin
      count   <= next_count;
      blocked <= next_blocked;
      flags   <= next_flags;
      oc_a    <= next_oc_a;
      oc_b    <= next_oc_b;
      pin_a   <= next_pin_a;
      pin_b   <= next_pin_b;
      oe_n_a  <= next_oe_n_a;
      oe_n_b  <= next_oe_n_b;
    end
  end

  assign COUNTER_VALUE_OUT          = count;
  assign FLAG_OUT                   = flags;
  assign COMPARE_A_OUTPUT_STATE_OUT = oc_a;
  assign COMPARE_B_OUTPUT_STATE_OUT = oc_b;
  assign PIN_A_OUT                  = pin_a;
  assign PIN_A_OE_N_OUT             = oe_n_a;
  assign PIN_B_OUT                  = pin_b;
  assign PIN_B_OE_N_OUT             = oe_n_b;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  // The first tick after a counter write may raise no compare flag on either channel
  property p_write_blocks;
    blocked && TICK_IN |=> !$rose(flags.cmpa) && !$rose(flags.cmpb);
  endproperty
  a_write_blocks: assert property (p_write_blocks) else $error("match after counter write set flag");

  property p_match_flag;
    !blocked && TICK_IN && count == COMPARE_A_VALUE_IN |=> flags.cmpa;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("compare A flag not set on match");

  property p_normal_wrap;
    WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_NORMAL && TICK_IN && !COUNTER_WR_IN &&
      count == tc16_pkg::CNT_MAX |=> count == tc16_pkg::CNT_BOTTOM && flags.ovf;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap or overflow wrong");

  property p_ctc_clear;
    WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_CTC_CMPA && TICK_IN && !blocked && !COUNTER_WR_IN &&
      count == COMPARE_A_VALUE_IN |=> count == tc16_pkg::CNT_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("counter not cleared at top");

  property p_missed_top;
    WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_CTC_CMPA && TICK_IN && !COUNTER_WR_IN &&
      count > COMPARE_A_VALUE_IN && count != tc16_pkg::CNT_MAX |=> count == 16'($past(count) + 16'h0001);
  endproperty
  a_missed_top: assert property (p_missed_top) else $error("counter did not run past a low top");

  property p_toggle;
    WAVEFORM_GEN_MODE_IN == tc16_pkg::WGM_CTC_CMPA && COMPARE_A_OUTPUT_MODE_IN == tc16_pkg::COM_TOGGLE &&
      match_a |=> oc_a != $past(oc_a);
  endproperty
  a_toggle: assert property (p_toggle) else $error("output A did not toggle");

  property p_mode_zero_holds;
    COMPARE_A_OUTPUT_MODE_IN == tc16_pkg::COM_NONE |=> $stable(oc_a);
  endproperty
  a_mode_zero_holds: assert property (p_mode_zero_holds) else $error("state changed with mode zero");

  property p_pin_override;
    COMPARE_A_OUTPUT_MODE_IN != tc16_pkg::COM_NONE |=> PIN_A_OUT == oc_a;
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("pin not driven from output state");

  property p_pin_dir;
    OUTPUT_A_PIN_DIRECTION_IN |=> !PIN_A_OE_N_OUT;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin driver not enabled by direction");

  property p_ovf_sticky;
    flags.ovf && !FLAG_CLR_IN.ovf |=> flags.ovf;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow cleared by counting");

  property p_force;
    non_pwm && FORCE_COMPARE_STROBE_A_IN && COMPARE_A_OUTPUT_MODE_IN == tc16_pkg::COM_SET &&
      !match_a && !TICK_IN && !COUNTER_WR_IN && !FLAG_CLR_IN.cmpa |=> oc_a && $stable(count) && $stable(flags.cmpa);
  endproperty
  a_force: assert property (p_force) else $error("force did not act on state alone");

endmodule

// file: testbench/tc16_pin_load.sv
// External load on a timer output pin, with a pull-down on the line
`timescale 1ns/1ps
module tc16_pin_load (
  input  wire logic pin_in,
  input  wire logic pin_oe_n_in,
  output logic      level_out
);
  // A released pin falls to the pull-down and never keeps the last driven value
  assign level_out = pin_oe_n_in ? 1'h0 : pin_in;
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the 16-bit timer core
`timescale 1ns/1ps
module tb_top;
  logic                  clk, nrst, tick, fa, wr, pa, da, lva, fb, pb, db;
  logic                  sa, sb, pin_a, paoe, pin_b, pboe;
  logic [3:0]            wgm;
  logic [1:0]            coma, comb;
  logic [15:0]           wd, cva, capv, cnt;
  tc16_pkg::tc16_flags_s fclr, flg;
  int                    fails, cmp_count;

  tc16_core i_tc16_core (
    .CLK_IN                    (clk),
    .NRST_IN                   (nrst),
    .TICK_IN                   (tick),
    .WAVEFORM_GEN_MODE_IN      (wgm),
    .COMPARE_A_OUTPUT_MODE_IN  (coma),
    .COMPARE_B_OUTPUT_MODE_IN  (comb),
    .FORCE_COMPARE_STROBE_A_IN (fa),
    .FORCE_COMPARE_STROBE_B_IN (fb),
    .COUNTER_WR_IN             (wr),
    .COUNTER_WDATA_IN          (wd),
    .COMPARE_A_VALUE_IN        (cva),
    .COMPARE_B_VALUE_IN        (16'h0007),
    .CAPTURE_VALUE_IN          (capv),
    .FLAG_CLR_IN               (fclr),
    .PORT_A_IN                 (pa),
    .PORT_B_IN                 (pb),
    .OUTPUT_A_PIN_DIRECTION_IN (da),
    .OUTPUT_B_PIN_DIRECTION_IN (db),
    .COUNTER_VALUE_OUT         (cnt),
    .FLAG_OUT                  (flg),
    .COMPARE_A_OUTPUT_STATE_OUT(sa),
    .COMPARE_B_OUTPUT_STATE_OUT(sb),
    .PIN_A_OUT                 (pin_a),
    .PIN_A_OE_N_OUT            (paoe),
    .PIN_B_OUT                 (pin_b),
    .PIN_B_OE_N_OUT            (pboe)
  );

  tc16_pin_load i_tc16_pin_load (
    .pin_in     (pin_a),
    .pin_oe_n_in(paoe),
    .level_out  (lva)
  );

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tk();
    @(posedge clk) tick <= 1'h1;
    @(posedge clk) tick <= 1'h0;
    #1;
  endtask

  task automatic cwr(input logic [15:0] v);
    @(posedge clk);
    wr <= 1'h1;
    wd <= v;
    @(posedge clk) wr <= 1'h0;
    #1;
  endtask

  task automatic frc(input logic [1:0] c);
    @(posedge clk);
    coma <= c;
    fa <= 1'h1;
    @(posedge clk) fa <= 1'h0;
    #1;
  endtask

  task automatic clr(input tc16_pkg::tc16_flags_s v);
    @(posedge clk) fclr <= v;
    @(posedge clk) fclr <= '0;
    #1;
  endtask

  task automatic t_reset();
    chk("count", cnt, 16'h0000);
    chk("flags", 16'(flg), 16'h0000);
    chk("state", 16'(sa), 16'h0000);
    chk("state b", 16'(sb), 16'h0000);
    chk("enable", 16'(paoe), 16'h0001);
    $display("reset test done");
  endtask

  task automatic t_normal();
    cwr(16'hFFFE);
    chk("count written", cnt, 16'hFFFE);
    wt(3);
    chk("count idle", cnt, 16'hFFFE);
    tk();
    tk();
    chk("count wrap", cnt, 16'h0000);
    chk("overflow", 16'(flg.ovf), 16'h0001);
    tk();
    chk("overflow kept", 16'(flg.ovf), 16'h0001);
    clr(4'h8);
    chk("overflow cleared", 16'(flg.ovf), 16'h0000);
    $display("normal test done");
  endtask

  task automatic t_block();
    cwr(16'h0007);
    tk();
    chk("count", cnt, 16'h0008);
    chk("blocked flag", 16'(flg.cmpb), 16'h0000);
    cwr(16'h0006);
    tk();
    tk();
    chk("match flag", 16'(flg.cmpb), 16'h0001);
    clr(4'h2);
    $display("block test done");
  endtask

  task automatic t_force();
    // Mode zero follows a high state so that a wrong clear would show
    logic [1:0] cm [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1};
    logic       ex [5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
    for (int i = 0; i < 5; i++)
    begin
      frc(cm[i]);
      chk("forced state", 16'(sa), 16'(ex[i]));
    end
    chk("count kept", cnt, 16'h0008);
    chk("no flag", 16'(flg.cmpa), 16'h0000);
    frc(2'h3);
    @(posedge clk) wgm <= 4'hF;
    frc(2'h2);
    chk("pwm force", 16'(sa), 16'h0001);
    @(posedge clk) wgm <= 4'h0;
    wt(1);
    chk("state kept", 16'(sa), 16'h0001);
    $display("force test done");
  endtask

  task automatic t_pin();
    chk("released", 16'(lva), 16'h0000);
    @(posedge clk) da <= 1'h1;
    wt(2);
    chk("pin state", 16'(lva), 16'h0001);
    @(posedge clk) coma <= 2'h0;
    wt(2);
    chk("pin port low", 16'(lva), 16'h0000);
    @(posedge clk) pa <= 1'h1;
    wt(2);
    chk("pin port high", 16'(lva), 16'h0001);
    $display("pin test done");
  endtask

  task automatic t_chan_b();
    @(posedge clk);
    comb <= 2'h3;
    fb   <= 1'h1;
    db   <= 1'h1;
    @(posedge clk) fb <= 1'h0;
    wt(1);
    chk("state b", 16'(sb), 16'h0001);
    chk("pin b", 16'(pin_b), 16'h0001);
    chk("enable b", 16'(pboe), 16'h0000);
    @(posedge clk);
    comb <= 2'h0;
    fb   <= 1'h1;
    @(posedge clk) fb <= 1'h0;
    wt(1);
    chk("pin b port", 16'(pin_b), 16'h0000);
    chk("state b kept", 16'(sb), 16'h0001);
    $display("channel b test done");
  endtask

  task automatic t_ctc();
    logic s = 1'h1;
    @(posedge clk);
    wgm <= 4'h4;
    cva <= 16'h0003;
    coma <= 2'h1;
    cwr(16'h0000);
    for (int i = 1; i <= 8; i++)
    begin
      tk();
      if (i % 4 == 0) s = ~s;
      chk("ctc count", cnt, 16'(i % 4));
      chk("toggle", 16'(sa), 16'(s));
    end
    chk("top flag", 16'(flg.cmpa), 16'h0001);
    chk("no overflow", 16'(flg.ovf), 16'h0000);
    cwr(16'hFFFE);
    tk();
    tk();
    chk("missed top", cnt, 16'h0000);
    chk("wrap overflow", 16'(flg.ovf), 16'h0001);
    clr(4'hF);
    @(posedge clk);
    wgm <= 4'hC;
    capv <= 16'h0002;
    repeat (3) tk();
    chk("cap top count", cnt, 16'h0000);
    chk("cap flag", 16'(flg.cap), 16'h0001);
    chk("cmpa idle", 16'(flg.cmpa), 16'h0000);
    $display("ctc test done");
  endtask

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #500000;
    fails++;
    final_report();
  end

  initial
  begin
    {nrst, tick, fa, wr, pa, da, wgm, coma} = '0;
    {fb, pb, db, comb} = '0;
    {wd, capv, fclr} = '0;
    cva = 16'h1000;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    wt(1);
    t_reset();
    t_normal();
    t_block();
    t_force();
    t_pin();
    t_chan_b();
    t_ctc();
    final_report();
  end
endmodule
